// ---- common/iift_defs.vh ----
`ifndef IIFT_DEFS_VH
`define IIFT_DEFS_VH
// Register byte addresses
`define IIFT_A_NCC    32'hfffff3d4
`define IIFT_A_IN_SERVICE_PRIORITY   32'hfffff1fa
`define IIFT_A_WATCHDOG_MODE_CTRL   32'hfffff384
`define IIFT_A_RISE   32'hfffff0c0
`define IIFT_A_FALL   32'hfffff0c2
`define IIFT_A_FLAG   32'hfffff0c4
// Reset values
`define IIFT_RST_8    8'h00
`define IIFT_RST_PSW  32'h00000020
// Status word fields
`define IIFT_PSW_ID   32'h00000020
`define IIFT_PSW_EP   32'h00000040
`define IIFT_PSW_NP   32'h00000080
// Watchdog sticky bits
`define IIFT_WD_STICK 8'h90
// Filter clock select field and codes
`define IIFT_SEL_M    8'h07
`define IIFT_SEL_FXX  3'h0
`define IIFT_SEL_64   3'h1
`define IIFT_SEL_128  3'h2
`define IIFT_SEL_256  3'h3
`define IIFT_SEL_512  3'h4
`define IIFT_SEL_1K   3'h5
`define IIFT_SEL_SUB  3'h7
// Filter reinitialise length in samples
`define IIFT_REINIT   2'h3
// Trap vectors and codes
`define IIFT_TRAP_H0  32'h00000040
`define IIFT_TRAP_H1  32'h00000050
`define IIFT_TRAP_C   16'h0040
`define IIFT_NMI_H    32'h00000010
`endif

// ---- hw/iift_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "iift_defs.vh"

module iift_top (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [31:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire [7:0]  reg_wmask,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire        reg_bit_rd,
    input  wire [2:0]  reg_bit_idx,
    output reg  [7:0]  reg_rdata,
    input  wire [6:0]  ext_pin,
    input  wire        sub_clk_pin,
    input  wire        standby,
    input  wire        mi_req,
    input  wire [2:0]  mi_level,
    input  wire [15:0] mi_code,
    input  wire [31:0] mi_handler,
    input  wire [31:0] mi_ret_pc,
    input  wire        mi_ext,
    input  wire [2:0]  mi_ext_idx,
    input  wire        nmi_req,
    input  wire [31:0] nmi_ret_pc,
    input  wire        instr_di,
    input  wire        instr_ei,
    input  wire        instr_return_from_interrupt_instr,
    input  wire        instr_system_register_load_instr,
    input  wire [31:0] system_register_load_instr_data,
    input  wire        instr_trap,
    input  wire [4:0]  trap_vec,
    input  wire [31:0] trap_ret_pc,
    output reg         mi_ack,
    output reg         nmi_ack,
    output reg         trap_ack,
    output reg         pc_load,
    output reg  [31:0] pc_value,
    output reg  [31:0] program_status_word,
    output reg  [31:0] exception_return_pc,
    output reg  [31:0] exception_return_status,
    output reg  [15:0] ecr_low,
    output reg  [6:0]  ext_flag
);

    // Byte merge under a bit mask
    function [7:0] f_merge;
        input [7:0] old;
        input [7:0] data;
        input [7:0] mask;
        begin
            f_merge = (old & ~mask) | (data & mask);
        end
    endfunction

    // Lowest set bit, i.e. highest priority level
    function [7:0] f_top;
        input [7:0] v;
        begin
            f_top = v & (~v + 8'h01);
        end
    endfunction

    // Levels at or above the given priority
    function [7:0] f_le;
        input [2:0] lvl;
        integer i;
        begin
            f_le = 8'h00;
            for (i = 0; i < 8; i = i + 1) begin
                if (i <= lvl)
                    f_le[i] = 1'b1;
            end
        end
    endfunction

    // Divided sample tick from the free counter
    function f_div;
        input [2:0] sel;
        input [9:0] c;
        begin
            case (sel)
                `IIFT_SEL_FXX: f_div = 1'b1;
                `IIFT_SEL_64:  f_div = &c[5:0];
                `IIFT_SEL_128: f_div = &c[6:0];
                `IIFT_SEL_256: f_div = &c[7:0];
                `IIFT_SEL_512: f_div = &c[8:0];
                `IIFT_SEL_1K:  f_div = &c[9:0];
                default:       f_div = 1'b0; // 110 prohibited: no sampling
            endcase
        end
    endfunction

    // Three-sample majority-free filter: all equal or hold
    function f_filt;
        input [2:0] s;
        input       old;
        begin
            if (s == 3'h7)
                f_filt = 1'b1;
            else if (s == 3'h0)
                f_filt = 1'b0;
            else
                f_filt = old;
        end
    endfunction

    reg  [7:0]  noise_filter_clock_select;
    reg  [7:0]  rise_en;
    reg  [7:0]  fall_en;
    reg  [7:0]  watchdog_mode_ctrl;
    reg  [7:0]  in_service_priority;
    reg  [31:0] fepc;
    reg  [31:0] fepsw;
    reg  [6:0]  pin_s1;
    reg  [6:0]  pin_s2;
    reg         sub_s1;
    reg         sub_s2;
    reg         sub_s3;
    reg  [9:0]  div_cnt;
    reg  [8:0]  smp;
    reg  [6:0]  lvl;
    reg  [1:0]  reinit;
    reg  [7:0]  next_rdata;
    reg  [6:0]  next_lvl;
    reg  [8:0]  next_smp;
    wire [2:0]  sel = noise_filter_clock_select[2:0];
    wire        sub_edge = sub_s2 & ~sub_s3;
    wire        tick45 = ~standby;
    wire        tick6;
    wire        cpu_busy;
    wire        mi_ok;
    wire        mi_take;
    wire [6:0]  rise;
    wire [6:0]  fall;
    wire [6:0]  hit;
    wire [6:0]  take_clr;
    wire [6:0]  sw_clr;
    wire        wr_ncc = reg_wr & (reg_addr == `IIFT_A_NCC);
    wire [7:0]  ncc_new = f_merge(noise_filter_clock_select, reg_wdata, reg_wmask) & `IIFT_SEL_M;

    // Standby stops the divided clock; only the subclock keeps pin seven alive
    assign tick6 = (sel == `IIFT_SEL_SUB) ? sub_edge :
                   (~standby & f_div(sel, div_cnt));

    // Instructions and NMI are serialised by the core; maskables fill idle slots
    assign cpu_busy = nmi_req | instr_trap | instr_return_from_interrupt_instr | instr_system_register_load_instr | instr_di | instr_ei;
    assign mi_ok = mi_req & ~|(program_status_word & `IIFT_PSW_ID) & ~|(program_status_word & `IIFT_PSW_NP)
                   & ~|(in_service_priority & f_le(mi_level));
    assign mi_take = mi_ok & ~cpu_busy;

    // Edge events from filtered levels
    assign rise = next_lvl & ~lvl;
    assign fall = ~next_lvl & lvl;
    assign hit = (rise & rise_en[6:0]) | (fall & fall_en[6:0]);
    assign take_clr = (mi_take & mi_ext) ? (7'h01 << mi_ext_idx) : 7'h00;
    assign sw_clr = (reg_wr & (reg_addr == `IIFT_A_FLAG)) ? (reg_wmask[6:0] & ~reg_wdata[6:0]) : 7'h00;

    // Pin and subclock synchronisers
    always @(posedge clk) begin
        if (!rst_n) begin
            pin_s1 <= 7'h00;
            pin_s2 <= 7'h00;
            sub_s1 <= 1'b0;
            sub_s2 <= 1'b0;
            sub_s3 <= 1'b0;
        end else begin
            pin_s1 <= ext_pin;
            pin_s2 <= pin_s1;
            sub_s1 <= sub_clk_pin;
            sub_s2 <= sub_s1;
            sub_s3 <= sub_s2;
        end
    end

    // Free divider for the pin seven sample clock
    always @(posedge clk) begin
        if (!rst_n)
            div_cnt <= 10'h000;
        else
            div_cnt <= div_cnt + 10'h001;
    end

    // Filter next state for all seven pins
    always @* begin
        next_smp = smp;
        next_lvl = lvl;
        // Pins one to four are filtered in analog ahead of us
        next_lvl[3:0] = pin_s2[3:0];
        if (tick45) begin
            next_smp[2:0] = {smp[1:0], pin_s2[4]};
            next_smp[5:3] = {smp[4:3], pin_s2[5]};
            next_lvl[4] = f_filt(next_smp[2:0], lvl[4]);
            next_lvl[5] = f_filt(next_smp[5:3], lvl[5]);
        end
        if (tick6) begin
            next_smp[8:6] = {smp[7:6], pin_s2[6]};
            // History is not trusted until refilled after a select change
            if (reinit == 2'h0)
                next_lvl[6] = f_filt(next_smp[8:6], lvl[6]);
        end
    end

    // Filter state, reinitialise count and request flags
    always @(posedge clk) begin
        if (!rst_n) begin
            smp <= 9'h000;
            lvl <= 7'h00;
            reinit <= 2'h0;
            ext_flag <= 7'h00;
        end else begin
            smp <= next_smp;
            lvl <= next_lvl;
            if (wr_ncc && (ncc_new[2:0] != sel))
                reinit <= `IIFT_REINIT;
            else if (tick6 && reinit != 2'h0)
                reinit <= reinit - 2'h1;
            // A new edge wins over either clear
            ext_flag <= (ext_flag & ~take_clr & ~sw_clr) | hit;
        end
    end

    // Software-visible control registers
    always @(posedge clk) begin
        if (!rst_n) begin
            noise_filter_clock_select <= `IIFT_RST_8;
            rise_en <= `IIFT_RST_8;
            fall_en <= `IIFT_RST_8;
            watchdog_mode_ctrl <= `IIFT_RST_8;
        end else if (reg_wr) begin
            if (reg_addr == `IIFT_A_NCC)
                noise_filter_clock_select <= ncc_new;
            if (reg_addr == `IIFT_A_RISE)
                rise_en <= f_merge(rise_en, reg_wdata, reg_wmask) & 8'h7f;
            if (reg_addr == `IIFT_A_FALL)
                fall_en <= f_merge(fall_en, reg_wdata, reg_wmask) & 8'h7f;
            // Sticky bits survive any write of zero
            if (reg_addr == `IIFT_A_WATCHDOG_MODE_CTRL)
                watchdog_mode_ctrl <= f_merge(watchdog_mode_ctrl, reg_wdata, reg_wmask) | (watchdog_mode_ctrl & `IIFT_WD_STICK);
        end
    end

    // Read mux; in-service register ignores writes
    always @* begin
        case (reg_addr)
            `IIFT_A_NCC:  next_rdata = noise_filter_clock_select;
            `IIFT_A_IN_SERVICE_PRIORITY: next_rdata = in_service_priority;
            `IIFT_A_WATCHDOG_MODE_CTRL: next_rdata = watchdog_mode_ctrl;
            `IIFT_A_RISE: next_rdata = rise_en;
            `IIFT_A_FALL: next_rdata = fall_en;
            `IIFT_A_FLAG: next_rdata = {1'b0, ext_flag};
            default:      next_rdata = 8'h00;
        endcase
        if (reg_bit_rd)
            next_rdata = {7'h00, next_rdata[reg_bit_idx]};
    end

    // Read data stands for one cycle only
    always @(posedge clk) begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 8'h00;
    end

    // Core event sequencer: entry, return and status word
    always @(posedge clk) begin
        if (!rst_n) begin
            program_status_word <= `IIFT_RST_PSW;
            exception_return_pc <= 32'h00000000;
            exception_return_status <= 32'h00000000;
            fepc <= 32'h00000000;
            fepsw <= 32'h00000000;
            ecr_low <= 16'h0000;
            in_service_priority <= 8'h00;
            pc_value <= 32'h00000000;
            pc_load <= 1'b0;
            mi_ack <= 1'b0;
            nmi_ack <= 1'b0;
            trap_ack <= 1'b0;
        end else begin
            pc_load <= 1'b0;
            mi_ack <= 1'b0;
            nmi_ack <= 1'b0;
            trap_ack <= 1'b0;
            if (nmi_req) begin
                // Taken whatever the disable flag says
                fepc <= nmi_ret_pc;
                fepsw <= program_status_word;
                program_status_word <= program_status_word | `IIFT_PSW_NP | `IIFT_PSW_ID;
                pc_value <= `IIFT_NMI_H;
                pc_load <= 1'b1;
                nmi_ack <= 1'b1;
            end else if (instr_trap) begin
                exception_return_pc <= trap_ret_pc;
                exception_return_status <= program_status_word;
                ecr_low <= `IIFT_TRAP_C | {11'h000, trap_vec};
                program_status_word <= program_status_word | `IIFT_PSW_EP | `IIFT_PSW_ID;
                pc_value <= trap_vec[4] ? `IIFT_TRAP_H1 : `IIFT_TRAP_H0;
                pc_load <= 1'b1;
                trap_ack <= 1'b1;
            end else if (instr_return_from_interrupt_instr) begin
                pc_load <= 1'b1;
                if (|(program_status_word & `IIFT_PSW_EP)) begin
                    pc_value <= exception_return_pc;
                    program_status_word <= exception_return_status;
                end else if (|(program_status_word & `IIFT_PSW_NP)) begin
                    pc_value <= fepc;
                    program_status_word <= fepsw;
                end else begin
                    pc_value <= exception_return_pc;
                    program_status_word <= exception_return_status;
                    in_service_priority <= in_service_priority & ~f_top(in_service_priority);
                end
            end else if (instr_system_register_load_instr) begin
                program_status_word <= system_register_load_instr_data;
            end else if (instr_di) begin
                program_status_word <= program_status_word | `IIFT_PSW_ID;
            end else if (instr_ei) begin
                program_status_word <= program_status_word & ~`IIFT_PSW_ID;
            end else if (mi_take) begin
                exception_return_pc <= mi_ret_pc;
                exception_return_status <= program_status_word;
                ecr_low <= mi_code;
                program_status_word <= program_status_word | `IIFT_PSW_ID;
                in_service_priority <= in_service_priority | (8'h01 << mi_level);
                pc_value <= mi_handler;
                pc_load <= 1'b1;
                mi_ack <= 1'b1;
            end
        end
    end

endmodule // iift_top
`default_nettype wire

// ---- dv/iift_chk_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "iift_defs.vh"
module iift_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        nmi_req,
    input wire logic        instr_di,
    input wire logic        instr_ei,
    input wire logic        instr_return_from_interrupt_instr,
    input wire logic        instr_system_register_load_instr,
    input wire logic [31:0] system_register_load_instr_data,
    input wire logic        instr_trap,
    input wire logic [4:0]  trap_vec,
    input wire logic [31:0] trap_ret_pc,
    input wire logic        mi_ack,
    input wire logic        nmi_ack,
    input wire logic        trap_ack,
    input wire logic        pc_load,
    input wire logic [31:0] pc_value,
    input wire logic [31:0] program_status_word,
    input wire logic [31:0] exception_return_pc,
    input wire logic [31:0] exception_return_status,
    input wire logic [15:0] ecr_low
);
    // One clock domain, so one clocking and one disable
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // NMI outranks every core event
    wire quiet = !nmi_req;
    AST_TRAP_ACK: assert property (instr_trap && quiet |=> trap_ack && pc_load)
        else $error("trap not taken");
    AST_TRAP_VEC: assert property (instr_trap && quiet |=>
        pc_value == ($past(trap_vec[4]) ? `IIFT_TRAP_H1 : `IIFT_TRAP_H0)) else $error("bad trap handler");
    AST_TRAP_SAVE: assert property (instr_trap && quiet |=> exception_return_pc == $past(trap_ret_pc)
        && exception_return_status == $past(program_status_word) && ecr_low == `IIFT_TRAP_C + $past(trap_vec)) else $error("bad trap save");
    AST_TRAP_FLAGS: assert property (instr_trap && quiet |=> program_status_word[6] && program_status_word[5])
        else $error("trap flags not set");
    AST_MI_DIS: assert property (mi_ack |-> program_status_word[5] && pc_load)
        else $error("accept left irqs enabled");
    AST_MI_GATE: assert property (mi_ack |-> !$past(program_status_word[5]))
        else $error("accept while disabled");
    AST_DI_EI: assert property ((instr_di || instr_ei) && quiet |=> program_status_word[5] == $past(instr_di))
        else $error("disable flag wrong");
    AST_SYSTEM_REGISTER_LOAD_INSTR: assert property (instr_system_register_load_instr && quiet |=> program_status_word[7:5] == $past(system_register_load_instr_data[7:5]))
        else $error("status load wrong");
    AST_NMI: assert property (nmi_req |=> nmi_ack)
        else $error("nmi not taken");
    AST_RETURN_FROM_INTERRUPT_INSTR_EP: assert property (instr_return_from_interrupt_instr && program_status_word[6] && quiet |=> pc_load
        && pc_value == $past(exception_return_pc) && program_status_word == $past(exception_return_status)) else $error("bad return");
    // Main scenarios reached
    COV_TRAP: cover property (trap_ack);
    COV_MI: cover property (mi_ack);
    COV_NMI: cover property (nmi_ack && program_status_word[5]);
endmodule // iift_chk
`default_nettype wire

// ---- dv/iift_pin_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module iift_pin_src (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [2:0] idx,
    input  wire logic [3:0] len,
    output logic      [6:0] ext_pin
);
    logic [3:0] cnt = 4'h0;
    initial ext_pin = 7'h00;
    // Pulse of len clocks; a filtered pin needs len >= 3 for a valid edge
    always @(posedge clk) begin
        if (go) begin
            ext_pin[idx] <= 1'b1;
            cnt <= len;
        end else if (cnt > 4'h1) begin
            cnt <= cnt - 4'h1;
        end else if (cnt == 4'h1) begin
            ext_pin <= 7'h00;
            cnt <= 4'h0;
        end
    end
endmodule // iift_pin_src
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "iift_defs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_bit_rd = 1'b0;
    logic        mi_req = 1'b0, mi_ext = 1'b0, nmi_req = 1'b0, go = 1'b0, ok;
    logic        sub_clk = 1'b0, sub_run = 1'b0, stby = 1'b0;
    logic        instr_di = 1'b0, instr_ei = 1'b0, instr_return_from_interrupt_instr = 1'b0, instr_system_register_load_instr = 1'b0, instr_trap = 1'b0;
    logic [2:0]  reg_bit_idx = 3'h0, mi_level = 3'h0, mi_ext_idx = 3'h0, pidx = 3'h0;
    logic [3:0]  plen = 4'h0;
    logic [4:0]  trap_vec = 5'h00;
    logic [7:0]  reg_wdata = 8'h00, reg_wmask = 8'h00, rd, reg_rdata;
    logic [31:0] reg_addr = 32'h0, system_register_load_instr_data = 32'h0, trap_ret_pc = 32'h0, mi_ret_pc = 32'h0;
    logic [31:0] nmi_ret_pc = 32'h0, old, pc_value, program_status_word, exception_return_pc, exception_return_status;
    logic        mi_ack, nmi_ack, trap_ack, pc_load;
    logic [15:0] ecr_low;
    logic [6:0]  ext_flag, ext_pin;
    int          fails = 0, total_checks = 0;
    always #10 clk = ~clk;
    // Slow subclock source, parked low when not in use
    always @(posedge clk) sub_clk <= sub_run ? ~sub_clk : 1'b0;
    iift_pin_src iift_pin_src_i (.clk(clk), .go(go), .idx(pidx), .len(plen), .ext_pin(ext_pin));
    iift_top iift_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wmask(reg_wmask), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bit_rd(reg_bit_rd),
        .reg_bit_idx(reg_bit_idx), .reg_rdata(reg_rdata), .ext_pin(ext_pin), .sub_clk_pin(sub_clk),
        .standby(stby), .mi_req(mi_req), .mi_level(mi_level), .mi_code(16'h0011),
        .mi_handler(32'h00000100), .mi_ret_pc(mi_ret_pc), .mi_ext(mi_ext), .mi_ext_idx(mi_ext_idx),
        .nmi_req(nmi_req), .nmi_ret_pc(nmi_ret_pc), .instr_di(instr_di), .instr_ei(instr_ei),
        .instr_return_from_interrupt_instr(instr_return_from_interrupt_instr), .instr_system_register_load_instr(instr_system_register_load_instr), .system_register_load_instr_data(system_register_load_instr_data),
        .instr_trap(instr_trap), .trap_vec(trap_vec), .trap_ret_pc(trap_ret_pc), .mi_ack(mi_ack),
        .nmi_ack(nmi_ack), .trap_ack(trap_ack), .pc_load(pc_load), .pc_value(pc_value), .program_status_word(program_status_word),
        .exception_return_pc(exception_return_pc), .exception_return_status(exception_return_status), .ecr_low(ecr_low), .ext_flag(ext_flag));
    task test_done;
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Register bus: one-cycle strobes, data in the cycle after a read
    task wr(input logic [31:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wmask <= m;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rdr(input logic [31:0] a, input logic b, input logic [2:0] i);
        @(posedge clk);
        reg_addr <= a;
        reg_bit_rd <= b;
        reg_bit_idx <= i;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    // Core event w = {trap, system_register_load_instr, return_from_interrupt_instr, ei, di}; d doubles as vector and data
    task ev(input logic [4:0] w, input logic [31:0] d);
        @(posedge clk);
        {instr_trap, instr_system_register_load_instr, instr_return_from_interrupt_instr, instr_ei, instr_di} <= w;
        system_register_load_instr_data <= d;
        trap_vec <= d[4:0];
        trap_ret_pc <= ~d;
        @(posedge clk);
        {instr_trap, instr_system_register_load_instr, instr_return_from_interrupt_instr, instr_ei, instr_di} <= 5'h00;
        #1;
    endtask
    task mreq(input logic [2:0] l, input logic e, input logic [2:0] i);
        @(posedge clk);
        mi_req <= 1'b1;
        mi_level <= l;
        mi_ret_pc <= {29'h0, l};
        mi_ext <= e;
        mi_ext_idx <= i;
    endtask
    // Request is held until the ack shows, then dropped
    task wack;
        ok = 1'b0;
        for (int n = 0; n < 8 && !ok; n++) begin
            @(posedge clk);
            #1 ok = (mi_ack === 1'b1);
        end
        @(posedge clk);
        mi_req <= 1'b0;
        if (!ok) begin
            fails++;
            test_done();
        end
    endtask
    task pin(input logic [2:0] i, input logic [3:0] l);
        @(posedge clk);
        go <= 1'b1;
        pidx <= i;
        plen <= l;
        @(posedge clk);
        go <= 1'b0;
        repeat (14) @(posedge clk);
        #1;
    endtask
    task t_reset;
        `CHK(program_status_word, `IIFT_RST_PSW)
        rdr(`IIFT_A_IN_SERVICE_PRIORITY, 1'b0, 3'h0);
        `CHK(rd, `IIFT_RST_8)
        rdr(`IIFT_A_NCC, 1'b0, 3'h0);
        `CHK(rd, `IIFT_RST_8)
        rdr(32'h00001000, 1'b0, 3'h0);
        `CHK(rd, 8'h00)
    endtask
    task t_mask;
        ev(5'h08, 32'h0);
        `CHK(program_status_word, 32'h0)
        mreq(3'h3, 1'b0, 3'h0);
        wack();
        `CHK(program_status_word[5], 1'b1)
        `CHK(pc_value, 32'h00000100)
        rdr(`IIFT_A_IN_SERVICE_PRIORITY, 1'b0, 3'h0);
        `CHK(rd, 8'h08)
        rdr(`IIFT_A_IN_SERVICE_PRIORITY, 1'b1, 3'h3);
        `CHK(rd, 8'h01)
        wr(`IIFT_A_IN_SERVICE_PRIORITY, 8'hff, 8'hff);
        rdr(`IIFT_A_IN_SERVICE_PRIORITY, 1'b0, 3'h0);
        `CHK(rd, 8'h08)
        mreq(3'h1, 1'b0, 3'h0);
        repeat (6) begin
            @(posedge clk);
            #1 `CHK(mi_ack, 1'b0)
        end
        ev(5'h02, 32'h0);
        wack();
        rdr(`IIFT_A_IN_SERVICE_PRIORITY, 1'b0, 3'h0);
        `CHK(rd, 8'h0a)
        ev(5'h04, 32'h0);
        rdr(`IIFT_A_IN_SERVICE_PRIORITY, 1'b0, 3'h0);
        `CHK(rd, 8'h08)
        ev(5'h01, 32'h0);
        `CHK(program_status_word[5], 1'b1)
    endtask
    task t_trap;
        old = program_status_word;
        ev(5'h10, 32'h13);
        `CHK(trap_ack, 1'b1)
        `CHK(pc_value, `IIFT_TRAP_H1)
        `CHK(ecr_low, `IIFT_TRAP_C + 16'h0013)
        `CHK({exception_return_pc, exception_return_status}, {~32'h13, old})
        `CHK(program_status_word[6:5], 2'h3)
        ev(5'h10, 32'h0f);
        `CHK(pc_value, `IIFT_TRAP_H0)
        ev(5'h04, 32'h0);
        `CHK(pc_value, ~32'h0f)
        rdr(`IIFT_A_IN_SERVICE_PRIORITY, 1'b0, 3'h0);
        `CHK(rd, 8'h08)
        @(posedge clk);
        nmi_req <= 1'b1;
        nmi_ret_pc <= 32'h00000044;
        @(posedge clk);
        nmi_req <= 1'b0;
        #1 `CHK(nmi_ack, 1'b1)
    endtask
    logic [2:0] ok_codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    task t_regs;
        wr(`IIFT_A_WATCHDOG_MODE_CTRL, 8'hff, 8'hff);
        wr(`IIFT_A_WATCHDOG_MODE_CTRL, 8'h00, 8'hff);
        rdr(`IIFT_A_WATCHDOG_MODE_CTRL, 1'b0, 3'h0);
        `CHK(rd, `IIFT_WD_STICK)
        foreach (ok_codes[k]) begin
            wr(`IIFT_A_NCC, {5'h00, ok_codes[k]}, 8'hff);
            rdr(`IIFT_A_NCC, 1'b0, 3'h0);
            `CHK(rd, {5'h00, ok_codes[k]})
        end
    endtask
    task t_pins;
        wr(`IIFT_A_NCC, 8'h00, 8'hff);
        wr(`IIFT_A_RISE, 8'h50, 8'hff);
        wr(`IIFT_A_FALL, 8'h20, 8'hff);
        repeat (8) @(posedge clk);
        wr(`IIFT_A_FLAG, 8'h00, 8'h7f);
        pin(3'h4, 4'h5);
        `CHK(ext_flag, 7'h10)
        pin(3'h5, 4'h5);
        `CHK(ext_flag, 7'h30)
        wr(`IIFT_A_FLAG, 8'h00, 8'h30);
        pin(3'h4, 4'h1);
        pin(3'h3, 4'h5);
        `CHK(ext_flag, 7'h00)
        pin(3'h6, 4'h5);
        `CHK(ext_flag, 7'h40)
        ev(5'h08, 32'h0);
        mreq(3'h0, 1'b1, 3'h6);
        wack();
        `CHK(ext_flag, 7'h00)
    endtask
    // Subclock keeps pin seven sampling while the fast clock sleeps
    task t_sub;
        wr(`IIFT_A_NCC, {5'h00, `IIFT_SEL_SUB}, 8'hff);
        sub_run <= 1'b1;
        stby <= 1'b1;
        repeat (12) @(posedge clk);
        pin(3'h6, 4'hf);
        `CHK(ext_flag, 7'h40)
        stby <= 1'b0;
        sub_run <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        t_reset();
        t_mask();
        t_trap();
        t_regs();
        t_pins();
        t_sub();
        test_done();
    end
    // Cut a hang short
    initial begin
        #200000;
        fails++;
        test_done();
    end
endmodule // tb_top
bind iift_top iift_chk iift_chk_i (.clk(clk), .rst_n(rst_n), .nmi_req(nmi_req), .instr_di(instr_di),
    .instr_ei(instr_ei), .instr_return_from_interrupt_instr(instr_return_from_interrupt_instr), .instr_system_register_load_instr(instr_system_register_load_instr), .system_register_load_instr_data(system_register_load_instr_data),
    .instr_trap(instr_trap), .trap_vec(trap_vec), .trap_ret_pc(trap_ret_pc), .mi_ack(mi_ack),
    .nmi_ack(nmi_ack), .trap_ack(trap_ack), .pc_load(pc_load), .pc_value(pc_value), .program_status_word(program_status_word),
    .exception_return_pc(exception_return_pc), .exception_return_status(exception_return_status), .ecr_low(ecr_low));
`default_nettype wire
